// file: hdl/pcoe_device.sv
`timescale 1ns/1ps
`default_nettype none
module pcoe_device
	import pcoe_pkg::*;
#(
	parameter bit six_channels = 1'b1,
	parameter int latch_cycles = pcoe_latch_cycles,
	parameter int off_cycles = pcoe_off_cycles
)
(
	input wire logic clock_in,
	input wire logic reset_in,
	pcoe_link_if.device_end link,
	output logic [pcoe_max_channels-1:0] channel_high_out,
	output logic [pcoe_max_channels-1:0] channel_low_out,
	output logic enabled_out
);
	logic sync_a_ff, sync_b_ff, prev_ff;
	logic nxt_prev;
	logic [pcoe_count_width-1:0] count_ff, nxt_count;
	logic [pcoe_timer_width-1:0] high_timer_ff, nxt_high_timer;
	logic [pcoe_timer_width-1:0] low_timer_ff, nxt_low_timer;
	logic [pcoe_max_channels-1:0] pattern_ff, nxt_pattern;
	logic enabled_ff, nxt_enabled;
	logic latched_ff, nxt_latched;
	logic rise;
	logic [pcoe_max_channels-1:0] channel_mask;
	// pull-down side of each channel, held in its own register
	logic [pcoe_max_channels-1:0] low_drive_ff, nxt_low_drive;
	// synchroniser next values and the last-state decode
	logic nxt_sync_a, nxt_sync_b;
	logic last_state;

	// decode count into on pattern; count-1 bits mark off channels
	function automatic logic [pcoe_max_channels-1:0] pcoe_decode(
		input logic [pcoe_count_width-1:0] count,
		input logic [pcoe_max_channels-1:0] mask
	);
		logic [pcoe_count_width-1:0] index;
		index = count - pcoe_count_one;
		return ~index[pcoe_max_channels-1:0] & mask;
	endfunction

	// smaller variant has channel six held off
	assign channel_mask = six_channels ? pcoe_all_on : {1'b0,
		pcoe_all_on[pcoe_small_channels-1:0]};

	// count has reached the last state of this variant
	function automatic logic pcoe_at_last(
		input logic [pcoe_count_width-1:0] count,
		input logic six
	);
		logic last;
		if (six)
			last = count[pcoe_max_channels];
		else
			last = count[pcoe_small_channels];
		return last;
	endfunction

	// next rising edge wraps the count back to one
	assign last_state = pcoe_at_last(count_ff, six_channels);

	// two-flop synchroniser on the control pin
	always_comb
	begin
		nxt_sync_a = link.control_line;
		nxt_sync_b = sync_a_ff;
	end

	// register the synchroniser stages
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			sync_a_ff <= 1'b0;
			sync_b_ff <= 1'b0;
		end
		else
		begin
			sync_a_ff <= nxt_sync_a;
			sync_b_ff <= nxt_sync_b;
		end
	end

	// rising edge of the synchronised pin
	assign rise = sync_b_ff & ~prev_ff;

	// edge counting, timeouts and latching
	always_comb
	begin
		nxt_prev = sync_b_ff;
		nxt_count = count_ff;
		nxt_high_timer = high_timer_ff;
		nxt_low_timer = low_timer_ff;
		nxt_pattern = pattern_ff;
		nxt_enabled = enabled_ff;
		nxt_latched = latched_ff;
		if (rise)
		begin
			// only the edge count selects the setting
			if (count_ff == pcoe_count_zero)
			begin
				nxt_count = pcoe_count_one;
				nxt_enabled = 1'b1;
				nxt_pattern = channel_mask;
			end
			else if (last_state)
				nxt_count = pcoe_count_one; // wrap past last state
			else
				nxt_count = count_ff + pcoe_count_one;
			nxt_high_timer = pcoe_timer_zero;
			nxt_latched = 1'b0;
		end
		if (sync_b_ff)
		begin
			nxt_low_timer = pcoe_timer_zero;
			if (!rise && !latched_ff && enabled_ff)
			begin
				if (high_timer_ff + pcoe_timer_one >=
					latch_cycles[pcoe_timer_width-1:0])
				begin
					nxt_pattern = pcoe_decode(count_ff, channel_mask);
					nxt_latched = 1'b1;
				end
				else
					nxt_high_timer = high_timer_ff + pcoe_timer_one;
			end
		end
		else if (enabled_ff)
		begin
			if (low_timer_ff + pcoe_timer_one >=
				off_cycles[pcoe_timer_width-1:0])
			begin
				nxt_enabled = 1'b0;
				nxt_count = pcoe_count_zero;
				nxt_pattern = pcoe_all_off;
				nxt_latched = 1'b0;
				nxt_low_timer = pcoe_timer_zero;
			end
			else
				nxt_low_timer = low_timer_ff + pcoe_timer_one;
		end
	end

	// register the counting group
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			prev_ff <= 1'b0;
			count_ff <= pcoe_count_zero;
			high_timer_ff <= pcoe_timer_zero;
			low_timer_ff <= pcoe_timer_zero;
			pattern_ff <= pcoe_all_off;
			enabled_ff <= 1'b0;
			latched_ff <= 1'b0;
		end
		else
		begin
			prev_ff <= nxt_prev;
			count_ff <= nxt_count;
			high_timer_ff <= nxt_high_timer;
			low_timer_ff <= nxt_low_timer;
			pattern_ff <= nxt_pattern;
			enabled_ff <= nxt_enabled;
			latched_ff <= nxt_latched;
		end
	end

	// pull-down side follows the next pattern, both sides switch together
	always_comb
	begin
		nxt_low_drive = ~nxt_pattern;
	end

	// register the pull-down side; at reset every channel is pulled low
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			low_drive_ff <= pcoe_all_on;
		else
			low_drive_ff <= nxt_low_drive;
	end

	// push/pull drive per channel: exactly one side active
	for (genvar k = 0; k < pcoe_max_channels; k++)
	begin : g_channel
		assign channel_high_out[k] = pattern_ff[k];
		assign channel_low_out[k] = low_drive_ff[k];
	end

	// enabled from the first edge until the off timeout
	assign enabled_out = enabled_ff;
endmodule
`default_nettype wire

// file: hdl/pcoe_pkg.sv
`default_nettype none
package pcoe_pkg;
	// channel count of the larger variant; smaller variant uses five
	localparam int pcoe_max_channels = 6;
	localparam int pcoe_small_channels = 5;
	// count register width, enough for 64 edges plus headroom
	localparam int pcoe_count_width = 7;
	// clock rate in kHz, timing figures in ns or us as each name says
	localparam int pcoe_clock_khz = 10000;
	localparam int pcoe_clock_period_ns = 100;
	localparam int pcoe_latch_timeout_us = 500;
	localparam int pcoe_off_timeout_us = 500;
	localparam int pcoe_high_min_ns = 50;
	localparam int pcoe_high_max_us = 75;
	localparam int pcoe_low_min_ns = 500;
	localparam int pcoe_low_max_us = 75;
	// longest times round down, least times round up, the high minimum never below one
	localparam int pcoe_latch_cycles =
		pcoe_latch_timeout_us * pcoe_clock_khz / 1000;
	localparam int pcoe_off_cycles =
		pcoe_off_timeout_us * pcoe_clock_khz / 1000;
	localparam int pcoe_high_min_raw =
		(pcoe_high_min_ns + pcoe_clock_period_ns - 1) / pcoe_clock_period_ns;
	localparam int pcoe_high_min_cycles =
		(pcoe_high_min_raw < 1) ? 1 : pcoe_high_min_raw;
	localparam int pcoe_low_min_cycles =
		(pcoe_low_min_ns + pcoe_clock_period_ns - 1) / pcoe_clock_period_ns;
	localparam int pcoe_high_max_cycles =
		pcoe_high_max_us * pcoe_clock_khz / 1000;
	localparam int pcoe_low_max_cycles =
		pcoe_low_max_us * pcoe_clock_khz / 1000;
	// timer width covers the longest count
	localparam int pcoe_timer_width = 16;
	localparam logic [pcoe_count_width-1:0] pcoe_count_zero = 7'h00;
	localparam logic [pcoe_count_width-1:0] pcoe_count_one = 7'h01;
	localparam logic [pcoe_max_channels-1:0] pcoe_all_off = 6'h00;
	localparam logic [pcoe_max_channels-1:0] pcoe_all_on = 6'h3f;
	localparam logic [pcoe_timer_width-1:0] pcoe_timer_zero = 16'h0000;
	localparam logic [pcoe_timer_width-1:0] pcoe_timer_one = 16'h0001;
	// host sequencer states
	typedef enum logic [4:0] {
		pcoe_h_idle = 5'h01,
		pcoe_h_high = 5'h02,
		pcoe_h_low = 5'h04,
		pcoe_h_hold = 5'h08,
		pcoe_h_off = 5'h10
	} pcoe_host_state_type;
endpackage
`default_nettype wire

// file: hdl/pcoe_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcoe_link_if;
	// the single serial control line, driven push/pull by the host
	logic control_line;
	modport host_end (output control_line);
	modport device_end (input control_line);
endinterface
`default_nettype wire

// file: hdl/pcoe_host.sv
`timescale 1ns/1ps
`default_nettype none
module pcoe_host
	import pcoe_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic start_in,
	input wire logic [pcoe_count_width-1:0] pulses_in,
	input wire logic shutdown_in,
	output logic busy_out,
	pcoe_link_if.host_end link
);
	pcoe_host_state_type state_ff, nxt_state;
	logic [pcoe_count_width-1:0] left_ff, nxt_left;
	logic [pcoe_timer_width-1:0] timer_ff, nxt_timer;
	logic line_ff, nxt_line;
	localparam logic [pcoe_timer_width-1:0] pulse_high =
		pcoe_high_min_cycles[pcoe_timer_width-1:0];
	localparam logic [pcoe_timer_width-1:0] pulse_low =
		pcoe_low_min_cycles[pcoe_timer_width-1:0];

	// pulse sequencer
	always_comb
	begin
		nxt_state = state_ff;
		nxt_left = left_ff;
		nxt_timer = timer_ff;
		nxt_line = line_ff;
		case (state_ff)
			pcoe_h_idle, pcoe_h_hold:
			begin
				if (start_in && pulses_in != pcoe_count_zero)
				begin
					nxt_left = pulses_in;
					nxt_timer = pcoe_timer_zero;
					if (line_ff)
					begin
						nxt_line = 1'b0; // drop before first pulse
						nxt_state = pcoe_h_low;
					end
					else
					begin
						nxt_line = 1'b1;
						nxt_state = pcoe_h_high;
					end
				end
				else if (shutdown_in)
				begin
					nxt_line = 1'b0;
					nxt_state = pcoe_h_off;
				end
			end
			pcoe_h_high:
			begin
				nxt_timer = timer_ff + pcoe_timer_one;
				if (timer_ff + pcoe_timer_one >= pulse_high)
				begin
					nxt_timer = pcoe_timer_zero;
					nxt_left = left_ff - pcoe_count_one;
					if (left_ff == pcoe_count_one)
						nxt_state = pcoe_h_hold;
					else
					begin
						nxt_line = 1'b0;
						nxt_state = pcoe_h_low;
					end
				end
			end
			pcoe_h_low:
			begin
				nxt_timer = timer_ff + pcoe_timer_one;
				if (timer_ff + pcoe_timer_one >= pulse_low)
				begin
					nxt_timer = pcoe_timer_zero;
					nxt_line = 1'b1;
					nxt_state = pcoe_h_high;
				end
			end
			pcoe_h_off:
			begin
				if (start_in && pulses_in != pcoe_count_zero)
				begin
					nxt_left = pulses_in;
					nxt_timer = pcoe_timer_zero;
					nxt_line = 1'b1;
					nxt_state = pcoe_h_high;
				end
			end
			default:
			begin
				nxt_state = pcoe_h_idle;
				nxt_line = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			state_ff <= pcoe_h_idle;
			left_ff <= pcoe_count_zero;
			timer_ff <= pcoe_timer_zero;
			line_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			left_ff <= nxt_left;
			timer_ff <= nxt_timer;
			line_ff <= nxt_line;
		end
	end

	assign link.control_line = line_ff;
	assign busy_out = (state_ff == pcoe_h_high) || (state_ff == pcoe_h_low);
endmodule
`default_nettype wire

// file: testbench/pcoe_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pcoe_checker
	import pcoe_pkg::*;
#(
	parameter int latch_cycles = 20,
	parameter int off_cycles = 30
)
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic control_line,
	input wire logic busy_out,
	input wire logic enabled_out,
	input wire logic [pcoe_max_channels-1:0] channel_high_out,
	input wire logic [pcoe_max_channels-1:0] channel_low_out
);
	logic [9:0] hi_ff, nxt_hi, lo_ff, nxt_lo;
	logic [6:0] rise_ff, nxt_rise, pat;
	logic line_ff;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);
	// run lengths of the line and rises since shutdown
	always_comb
	begin
		nxt_hi = control_line ? hi_ff + {9'h000, ~&hi_ff} : 10'h000;
		nxt_lo = control_line ? 10'h000 : lo_ff + {9'h000, ~&lo_ff};
		nxt_rise = rise_ff;
		if (lo_ff == 10'(off_cycles + 5))
			nxt_rise = 7'h00;
		else if (control_line && !line_ff)
			nxt_rise = (rise_ff == 7'h40) ? 7'h01 : rise_ff + 7'h01;
		pat = rise_ff - 7'h01;
	end
	// helper registers
	always_ff @(posedge clock_in)
	begin
		hi_ff <= reset_in ? 10'h000 : nxt_hi;
		lo_ff <= reset_in ? 10'h000 : nxt_lo;
		rise_ff <= reset_in ? 7'h00 : nxt_rise;
		line_ff <= reset_in ? 1'b0 : control_line;
	end
	sequence s_all_on;
		##[2:3] enabled_out && channel_high_out == pcoe_all_on;
	endsequence
	a_drive_pairs: assert property (
		channel_high_out == ~channel_low_out)
		else $error("high and low drive disagree");
	a_first_on: assert property (
		$rose(control_line) && !enabled_out |-> s_all_on)
		else $error("first edge did not enable all");
	a_no_early_off: assert property (
		enabled_out && lo_ff < 10'(off_cycles) |=> enabled_out)
		else $error("disabled too early");
	a_off_clears: assert property (
		lo_ff == 10'(off_cycles + 5)
		|-> !enabled_out && channel_high_out == pcoe_all_off)
		else $error("not off after timeout");
	a_latch_wait: assert property (
		$changed(channel_high_out) && $past(enabled_out) && enabled_out
		|-> hi_ff >= 10'(latch_cycles))
		else $error("pattern changed before latch");
	a_pattern_count: assert property (
		hi_ff == 10'(latch_cycles + 6) && rise_ff != 7'h00
		|-> channel_high_out == ~pat[5:0])
		else $error("pattern does not match edges");
	a_low_gap: assert property (
		$fell(control_line) |-> !control_line [*5])
		else $error("low gap too short");
	a_high_bound: assert property (
		busy_out |-> hi_ff < 10'(pcoe_high_max_cycles))
		else $error("high phase too long");
endmodule
`default_nettype wire

// file: testbench/pulse_count_output_expander_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_count_output_expander_tb;
	import pcoe_pkg::*;
	localparam int lat = 20;
	localparam int off = 30;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic start_in = 1'b0;
	logic shutdown_in = 1'b0;
	logic [pcoe_count_width-1:0] pulses_in = 7'h01;
	logic busy_out, enabled_out;
	logic [pcoe_max_channels-1:0] high_w, low_w;
	logic [pcoe_max_channels-1:0] high5_w, low5_w;
	logic enabled5_w;
	int failures = 0;
	int n_tests = 0;
	int cnt = 0;
	int cnt5 = 0;
	pcoe_link_if link ();
	pcoe_host pcoe_host_inst (.clock_in(clock_in), .reset_in(reset_in),
		.start_in(start_in), .pulses_in(pulses_in),
		.shutdown_in(shutdown_in), .busy_out(busy_out), .link(link));
	pcoe_device #(.six_channels(1'b1), .latch_cycles(lat),
		.off_cycles(off)) pcoe_device_inst (.clock_in(clock_in),
		.reset_in(reset_in), .link(link), .channel_high_out(high_w),
		.channel_low_out(low_w), .enabled_out(enabled_out));
	// five-channel variant listening on the same line
	pcoe_device #(.six_channels(1'b0), .latch_cycles(lat),
		.off_cycles(off)) pcoe_device_five_inst (.clock_in(clock_in),
		.reset_in(reset_in), .link(link), .channel_high_out(high5_w),
		.channel_low_out(low5_w), .enabled_out(enabled5_w));
	pcoe_checker #(.latch_cycles(lat), .off_cycles(off)) pcoe_checker_inst (
		.clock_in(clock_in), .reset_in(reset_in),
		.control_line(link.control_line), .busy_out(busy_out),
		.enabled_out(enabled_out), .channel_high_out(high_w),
		.channel_low_out(low_w));
	// clock source
	always #50 clock_in = ~clock_in;
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [5:0] exp, input logic [5:0] exp5,
		input logic en);
		n_tests++;
		if (high_w !== exp || low_w !== ~exp || enabled_out !== en ||
			high5_w !== exp5 || low5_w !== ~exp5 || enabled5_w !== en)
		begin
			failures++;
			$display("CHECK FAILED t=%0t %h %h %h %h %b %b want %h %h %b",
				$time, high_w, low_w, high5_w, low5_w, enabled_out,
				enabled5_w, exp, exp5, en);
		end
	endtask
	// one pulse sequence, then wait out the latch time
	task automatic send(input int n);
		int i;
		@(negedge clock_in);
		pulses_in = 7'(n);
		start_in = 1'b1;
		@(negedge clock_in);
		start_in = 1'b0;
		i = 0;
		while (busy_out !== 1'b0 && i < 1000)
		begin
			@(negedge clock_in);
			i++;
		end
		if (i >= 1000)
		begin
			failures++;
			$display("CHECK FAILED t=%0t host stayed busy", $time);
		end
		repeat (lat + 8) @(negedge clock_in);
		cnt = (cnt + n - 1) % 64 + 1;
		cnt5 = (cnt5 + n - 1) % 32 + 1;
	endtask
	task automatic shut;
		@(negedge clock_in);
		shutdown_in = 1'b1;
		@(negedge clock_in);
		shutdown_in = 1'b0;
		repeat (off + 8) @(negedge clock_in);
		cnt = 0;
		cnt5 = 0;
	endtask
	// main sequence
	initial
	begin
		repeat (3) @(negedge clock_in);
		reset_in = 1'b0;
		chk(6'h00, 6'h00, 1'b0);
		for (int n = 1; n <= 64; n++)
		begin
			send(n);
			chk(~6'(cnt - 1), {1'b0, ~5'(cnt5 - 1)}, 1'b1);
			shut();
			chk(6'h00, 6'h00, 1'b0);
		end
		$display("test every count done");
		send(64);
		send(1);
		chk(6'h3f, 6'h1f, 1'b1);
		send(2);
		chk(~6'(cnt - 1), {1'b0, ~5'(cnt5 - 1)}, 1'b1);
		shut();
		$display("test accumulate and wrap done");
		end_of_test();
	end
	// watchdog
	initial
	begin
		repeat (60000) @(posedge clock_in);
		failures++;
		end_of_test();
	end
endmodule
`default_nettype wire
